//--- logic/pcicap_port.sv
// Host I/O port pair that turns data-window accesses into config cycles
`timescale 1ns/1ps
// Summary of operation
// RULE1: Selector register at I/O 0CF8h and data window at I/O 0CFCh.
// RULE2: Data-window access after selector write runs the config transfer.
// RULE3: Data-window byte enables pick which config bytes are accessed.
// RULE4: Only full dword accesses with all lanes reach the selector.
// RULE5: Byte or word selector-port accesses go out as ordinary I/O.
// RULE6: Bus number comes from selector bits 23 to 16.
// RULE7: Device number comes from selector bits 15 to 11.
// RULE8: Function number comes from selector bits 10 to 8.
// RULE9: Register index comes from selector bits 7 to 2.
// RULE10: Only the boot processor should issue configuration accesses.
// RULE11: Config cycles start only while selector bit 31 is set.
// RULE12: Selector bits 1 and 0 are ignored and read back as zero.
module pcicap_port
  import pcicap_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Host I/O request
  input wire logic io_req,
  input wire logic io_write,
  input wire logic [15:0] io_addr,
  input wire logic [3:0] io_be,
  input wire logic [31:0] io_wdata,
  // Host I/O answer
  output logic io_ready,
  output logic io_ack,
  output logic [31:0] io_rdata,
  // Ordinary I/O forwarded to the rest of the system
  output logic fwd_req,
  output logic fwd_write,
  output logic [15:0] fwd_addr,
  output logic [3:0] fwd_be,
  output logic [31:0] fwd_wdata,
  input wire logic [31:0] fwd_rdata,
  input wire logic fwd_ack,
  // Configuration cycle to the targets
  output logic cfg_req,
  output logic cfg_write,
  output logic [7:0] cfg_bus,
  output logic [4:0] cfg_dev,
  output logic [2:0] cfg_func,
  output logic [5:0] cfg_reg,
  output logic [3:0] cfg_be,
  output logic [31:0] cfg_wdata,
  input wire logic [31:0] cfg_rdata,
  input wire logic cfg_ack,
  // Selector state for observation
  output logic [31:0] target_select
);

  pcicap_state_e state;
  pcicap_state_e next_state;

  logic [31:0] config_target_select;
  logic [31:0] next_io_rdata;
  logic next_io_ack;

  pcicap_xfer_if fwd_if ();
  pcicap_xfer_if cfg_if ();

  // Decode of the incoming request
  wire logic io_take = io_req && io_ready;
  wire logic at_sel = io_addr[15:2] == PCICAP_SEL_PORT[15:2]; // RULE1
  wire logic at_data = io_addr[15:2] == PCICAP_DATA_PORT[15:2]; // RULE1
  wire logic full_dword = io_be == PCICAP_BE_ALL;
  wire logic sel_enabled = config_target_select[PCICAP_EN_BIT];
  wire logic sel_hit = at_sel && full_dword; // RULE4 RULE5
  wire logic data_hit = at_data && sel_enabled; // RULE2 RULE11
  wire logic no_lanes = io_be == PCICAP_BE_NONE;

  wire logic sel_write = io_take && sel_hit && io_write;
  wire logic start_cfg = io_take && data_hit && !no_lanes; // RULE2
  wire logic start_fwd = io_take && !sel_hit && !data_hit; // RULE5 RULE11

  // Selector fields that form the configuration address
  wire logic [7:0] sel_bus =
    config_target_select[PCICAP_BUS_HI:PCICAP_BUS_LO]; // RULE6
  wire logic [4:0] sel_dev =
    config_target_select[PCICAP_DEV_HI:PCICAP_DEV_LO]; // RULE7
  wire logic [2:0] sel_func =
    config_target_select[PCICAP_FUNC_HI:PCICAP_FUNC_LO]; // RULE8
  wire logic [5:0] sel_reg =
    config_target_select[PCICAP_REG_HI:PCICAP_REG_LO]; // RULE9
  wire logic [31:0] cfg_addr =
    {sel_enabled, 7'h00, sel_bus, sel_dev, sel_func, sel_reg, 2'h0};

  // Low selector bits are never stored, so a readback shows them as zero
  wire logic [31:0] sel_rd = config_target_select & PCICAP_SEL_MASK; // RULE12

  // Lanes the host did not enable read back as zero
  wire logic [31:0] lane_mask = {{8{cfg_be[3]}}, {8{cfg_be[2]}},
                                 {8{cfg_be[1]}}, {8{cfg_be[0]}}};

  logic fwd_done;
  logic [31:0] fwd_done_rdata;
  logic cfg_done;
  logic [31:0] cfg_done_rdata;

  pcicap_xfer u_fwd (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .start(start_fwd),
    .start_write(io_write),
    .start_addr({16'h0000, io_addr}),
    .start_be(io_be),
    .start_wdata(io_wdata),
    .done(fwd_done),
    .done_rdata(fwd_done_rdata),
    .bus(fwd_if.initiator)
  );

  pcicap_xfer u_cfg (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .start(start_cfg),
    .start_write(io_write),
    .start_addr(cfg_addr),
    .start_be(io_be), // RULE3
    .start_wdata(io_wdata),
    .done(cfg_done),
    .done_rdata(cfg_done_rdata),
    .bus(cfg_if.initiator)
  );

  // Forwarded I/O pins
  assign fwd_req = fwd_if.req;
  assign fwd_write = fwd_if.write;
  assign fwd_addr = fwd_if.addr[15:0];
  assign fwd_be = fwd_if.be;
  assign fwd_wdata = fwd_if.wdata;
  assign fwd_if.rdata = fwd_rdata;
  assign fwd_if.ack = fwd_ack;

  // Configuration pins
  assign cfg_req = cfg_if.req;
  assign cfg_write = cfg_if.write;
  assign cfg_bus = cfg_if.addr[PCICAP_BUS_HI:PCICAP_BUS_LO];
  assign cfg_dev = cfg_if.addr[PCICAP_DEV_HI:PCICAP_DEV_LO];
  assign cfg_func = cfg_if.addr[PCICAP_FUNC_HI:PCICAP_FUNC_LO];
  assign cfg_reg = cfg_if.addr[PCICAP_REG_HI:PCICAP_REG_LO];
  assign cfg_be = cfg_if.be; // RULE3
  assign cfg_wdata = cfg_if.wdata;
  assign cfg_if.rdata = cfg_rdata;
  assign cfg_if.ack = cfg_ack;

  // One host access in flight at a time; new requests wait in idle
  assign io_ready = state == PCICAP_IDLE;
  assign target_select = sel_rd;

  always_comb begin
    next_state = state;
    next_io_ack = 1'b0;
    next_io_rdata = io_rdata;
    unique case (state)
      PCICAP_IDLE: begin
        if (io_take) begin
          if (sel_hit) begin
            next_io_ack = 1'b1;
            next_io_rdata = io_write ? io_rdata : sel_rd; // RULE12
          end else if (data_hit && no_lanes) begin
            // No lane enabled: nothing in the target is touched
            next_io_ack = 1'b1; // RULE3
            next_io_rdata = PCICAP_DATA_RESET;
          end else if (data_hit) begin
            next_state = PCICAP_CFG;
          end else begin
            next_state = PCICAP_FWD;
          end
        end
      end
      PCICAP_FWD: begin
        if (fwd_done) begin
          next_state = PCICAP_IDLE;
          next_io_ack = 1'b1;
          next_io_rdata = fwd_write ? io_rdata : fwd_done_rdata;
        end
      end
      PCICAP_CFG: begin
        if (cfg_done) begin
          next_state = PCICAP_IDLE;
          next_io_ack = 1'b1;
          next_io_rdata =
            cfg_write ? io_rdata : (cfg_done_rdata & lane_mask); // RULE3
        end
      end
      // The fourth state code is never entered; recover to idle
      default: next_state = PCICAP_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state <= PCICAP_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      io_ack <= 1'b0;
      io_rdata <= PCICAP_DATA_RESET;
    end else begin
      io_ack <= next_io_ack;
      io_rdata <= next_io_rdata;
    end
  end

  // A write takes every bit but the two alignment bits
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      config_target_select <= PCICAP_SEL_RESET;
    end else if (sel_write) begin
      config_target_select <= io_wdata & PCICAP_SEL_MASK; // RULE4 RULE12
    end
  end

endmodule : pcicap_port

//--- logic/pcicap_pkg.sv
// Constants and types shared by the configuration access port
package pcicap_pkg;

  // I/O port addresses of the two dword registers
  localparam logic [15:0] PCICAP_SEL_PORT = 16'h0CF8;
  localparam logic [15:0] PCICAP_DATA_PORT = 16'h0CFC;

  // Target selector layout
  localparam int PCICAP_EN_BIT = 31;
  localparam int PCICAP_BUS_HI = 23;
  localparam int PCICAP_BUS_LO = 16;
  localparam int PCICAP_DEV_HI = 15;
  localparam int PCICAP_DEV_LO = 11;
  localparam int PCICAP_FUNC_HI = 10;
  localparam int PCICAP_FUNC_LO = 8;
  localparam int PCICAP_REG_HI = 7;
  localparam int PCICAP_REG_LO = 2;
  localparam logic [31:0] PCICAP_SEL_MASK = 32'hFFFF_FFFC;
  localparam logic [31:0] PCICAP_SEL_RESET = 32'h0000_0000;

  // Byte lane patterns
  localparam logic [3:0] PCICAP_BE_ALL = 4'hF;
  localparam logic [3:0] PCICAP_BE_NONE = 4'h0;
  localparam logic [31:0] PCICAP_DATA_RESET = 32'h0000_0000;

  typedef enum logic [1:0] {
    PCICAP_IDLE,
    PCICAP_FWD,
    PCICAP_CFG
  } pcicap_state_e;

endpackage : pcicap_pkg

//--- logic/pcicap_xfer_if.sv
// Request and answer channel between the port logic and a transfer engine
`timescale 1ns/1ps
interface pcicap_xfer_if;
  logic req;
  logic write;
  logic [31:0] addr;
  logic [3:0] be;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic ack;

  modport initiator (
    output req,
    output write,
    output addr,
    output be,
    output wdata,
    input rdata,
    input ack
  );

  modport target (
    input req,
    input write,
    input addr,
    input be,
    input wdata,
    output rdata,
    output ack
  );
endinterface : pcicap_xfer_if

//--- logic/pcicap_xfer.sv
// One outstanding transfer: holds a request until the target answers
`timescale 1ns/1ps
module pcicap_xfer
  import pcicap_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Start of a transfer from the port logic
  input wire logic start,
  input wire logic start_write,
  input wire logic [31:0] start_addr,
  input wire logic [3:0] start_be,
  input wire logic [31:0] start_wdata,
  // Completion back to the port logic
  output logic done,
  output logic [31:0] done_rdata,
  // Outgoing channel
  pcicap_xfer_if.initiator bus
);

  logic req;
  logic write;
  logic [31:0] addr;
  logic [3:0] be;
  logic [31:0] wdata;

  wire logic take_ack = req && bus.ack;

  assign bus.req = req;
  assign bus.write = write;
  assign bus.addr = addr;
  assign bus.be = be;
  assign bus.wdata = wdata;

  // Start is only issued while idle, so it never overlaps a held request
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      req <= 1'b0;
      write <= 1'b0;
      addr <= PCICAP_SEL_RESET;
      be <= PCICAP_BE_NONE;
      wdata <= PCICAP_DATA_RESET;
    end else if (start) begin
      req <= 1'b1;
      write <= start_write;
      addr <= start_addr;
      be <= start_be;
      wdata <= start_wdata;
    end else if (take_ack) begin
      req <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      done <= 1'b0;
      done_rdata <= PCICAP_DATA_RESET;
    end else begin
      done <= take_ack;
      if (take_ack) begin
        done_rdata <= bus.rdata;
      end
    end
  end

endmodule : pcicap_xfer

//--- verification/pcicap_tgt_model.sv
// Far-side responder for config cycles and forwarded I/O
`timescale 1ns/1ps
module pcicap_tgt_model (
  // Clock, reset and answer delay
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [3:0] lag,
  // Config target
  input wire logic cfg_req,
  input wire logic cfg_write,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata,
  output logic cfg_ack,
  output logic [31:0] cfg_rdata,
  // Forwarded I/O
  input wire logic fwd_req,
  input wire logic [15:0] fwd_addr,
  output logic fwd_ack,
  output logic [31:0] fwd_rdata
);
  logic [3:0] cnt;
  logic [31:0] mem;
  wire go = cnt >= lag;
  wire busy = (cfg_req || fwd_req) && !cfg_ack && !fwd_ack;
  // Lines carry junk outside an answer so stale data never passes
  assign cfg_rdata = cfg_ack ? mem : ~mem;
  // Forwarded reads echo the port address so a stale answer shows up
  assign fwd_rdata = fwd_ack ? {16'hA5A5, fwd_addr} : {16'h5A5A, ~fwd_addr};
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cnt <= 4'h0;
      cfg_ack <= 1'b0;
      fwd_ack <= 1'b0;
      mem <= 32'h0000_0000;
    end else begin
      cnt <= busy ? cnt + 4'h1 : 4'h0;
      cfg_ack <= cfg_req && !cfg_ack && go;
      fwd_ack <= fwd_req && !fwd_ack && go;
      for (int i = 0; i < 4; i++) begin
        if (cfg_req && cfg_ack && cfg_write && cfg_be[i]) begin
          mem[8*i +: 8] <= cfg_wdata[8*i +: 8];
        end
      end
    end
  end
endmodule : pcicap_tgt_model

//--- verification/pcicap_port_asserts.sv
// Concurrent checks on the config access port pins
`timescale 1ns/1ps
module pcicap_port_chk (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Host side
  input wire logic io_req,
  input wire logic io_write,
  input wire logic [15:0] io_addr,
  input wire logic [3:0] io_be,
  input wire logic [31:0] io_wdata,
  input wire logic io_ready,
  input wire logic io_ack,
  // Far side
  input wire logic fwd_req,
  input wire logic [15:0] fwd_addr,
  input wire logic cfg_req,
  input wire logic [7:0] cfg_bus,
  input wire logic [4:0] cfg_dev,
  input wire logic [2:0] cfg_func,
  input wire logic [5:0] cfg_reg,
  input wire logic [3:0] cfg_be,
  input wire logic cfg_ack,
  input wire logic [31:0] target_select
);
  wire tk = io_req && io_ready;
  wire sel = tk && io_addr[15:2] == 14'h33E;
  wire dat = tk && io_addr[15:2] == 14'h33F;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  sel_low_a: assert property (target_select[1:0] == 2'h0)
    else $error("selector low bits set");
  sel_write_a: assert property (sel && io_write && io_be == 4'hF |=>
    io_ack && target_select == ($past(io_wdata) & 32'hFFFF_FFFC))
    else $error("selector write lost");
  part_sel_a: assert property (sel && io_be != 4'hF |=>
    fwd_req && $stable(target_select)) else $error("partial selector use");
  cfg_go_a: assert property (dat && io_be != 4'h0 &&
    target_select[31] |=> cfg_req && !fwd_req) else $error("no cfg cycle");
  cfg_off_a: assert property (dat && !target_select[31] |=>
    fwd_req && !cfg_req) else $error("window not forwarded");
  cfg_be_a: assert property ($rose(cfg_req) |->
    cfg_be == $past(io_be)) else $error("cfg lanes differ");
  cfg_addr_a: assert property (cfg_req |->
    {cfg_bus, cfg_dev, cfg_func, cfg_reg} == target_select[23:2])
    else $error("cfg target differs");
  cfg_done_a: assert property (cfg_req && cfg_ack |=>
    !cfg_req ##1 io_ack) else $error("cfg answer late");
  fwd_addr_a: assert property ($rose(fwd_req) |->
    fwd_addr == $past(io_addr)) else $error("forward address differs");
  busy_ready_a: assert property ((cfg_req || fwd_req) |-> !io_ready)
    else $error("ready while busy");
endmodule : pcicap_port_chk
bind pcicap_port pcicap_port_chk i_pcicap_port_chk (
  .ref_clk, .nrst, .io_req, .io_write, .io_addr, .io_be, .io_wdata,
  .io_ready, .io_ack, .fwd_req, .fwd_addr, .cfg_req, .cfg_bus, .cfg_dev,
  .cfg_func, .cfg_reg, .cfg_be, .cfg_ack, .target_select
);

//--- verification/pcicap_port_bench.sv
// Self-checking bench for the config access port
`timescale 1ns/1ps
module pcicap_port_bench;
  logic ref_clk, nrst, io_req, io_write, io_ready, io_ack, fwd_req;
  logic fwd_write, fwd_ack, cfg_req, cfg_write, cfg_ack;
  logic [15:0] io_addr, fwd_addr;
  logic [7:0] cfg_bus;
  logic [4:0] cfg_dev;
  logic [2:0] cfg_func;
  logic [5:0] cfg_reg;
  logic [3:0] io_be, fwd_be, cfg_be, lag;
  logic [31:0] io_wdata, io_rdata, fwd_wdata, fwd_rdata, cfg_wdata;
  logic [31:0] cfg_rdata, target_select, rd;
  logic [21:0] seen;
  logic [52:0] fseen;
  logic [31:0] sels [3] = '{32'h80FF_FFFC, 32'h8000_0003, 32'h80A5_5A58};
  int fails = 0;
  int cmp_count = 0;
  int cyc = 0;
  pcicap_port i_pcicap_port (
    .ref_clk, .nrst, .io_req, .io_write, .io_addr, .io_be, .io_wdata,
    .io_ready, .io_ack, .io_rdata, .fwd_req, .fwd_write, .fwd_addr,
    .fwd_be, .fwd_wdata, .fwd_rdata, .fwd_ack, .cfg_req, .cfg_write,
    .cfg_bus, .cfg_dev, .cfg_func, .cfg_reg, .cfg_be, .cfg_wdata,
    .cfg_rdata, .cfg_ack, .target_select
  );
  pcicap_tgt_model i_pcicap_tgt_model (
    .ref_clk, .nrst, .lag, .cfg_req, .cfg_write, .cfg_be, .cfg_wdata,
    .cfg_ack, .cfg_rdata, .fwd_req, .fwd_addr, .fwd_ack, .fwd_rdata
  );
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (cfg_req) seen <= {cfg_bus, cfg_dev, cfg_func, cfg_reg};
    if (fwd_req) fseen <= {fwd_write, fwd_be, fwd_addr, fwd_wdata};
    cyc++;
    if (cyc == 3000) begin
      fails++;
      end_of_test();
    end
  end
  task automatic chk(input string nm, input logic [31:0] s, e);
    cmp_count++;
    if (s !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  // One host issues every access, one at a time
  task automatic io(input logic w, input logic [15:0] a,
      input logic [3:0] b, input logic [31:0] d);
    int n = 0;
    @(posedge ref_clk);
    io_req <= 1'b1;
    io_write <= w;
    io_addr <= a;
    io_be <= b;
    io_wdata <= d;
    @(posedge ref_clk);
    io_req <= 1'b0;
    #1;
    while (io_ack !== 1'b1 && n < 40) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    if (n == 40) fails++;
    rd = io_rdata;
  endtask : io
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_of_test
  initial begin
    nrst = 1'b0;
    io_req = 1'b0;
    io_write = 1'b0;
    io_addr = 16'h0000;
    io_be = 4'h0;
    io_wdata = 32'h0;
    lag = 4'h0;
    repeat (20) @(posedge ref_clk);
    nrst <= 1'b1;
    chk("sel reset", target_select, 32'h0);
    io(1'b1, 16'h0CF8, 4'hF, 32'h8012_3457);
    chk("sel write", target_select, 32'h8012_3454);
    io(1'b0, 16'h0CF8, 4'hF, 32'h0);
    chk("sel read", rd, 32'h8012_3454);
    $display("test selector done");
    for (int k = 0; k < 2; k++) begin
      lag <= 4'(3 * k);
      io(1'b1, 16'h0CFC, 4'hF, 32'h1122_3344);
      io(1'b0, 16'h0CFC, 4'hF, 32'h0);
      chk("cfg read", rd, 32'h1122_3344);
    end
    io(1'b1, 16'h0CFC, 4'h2, 32'hAABB_CCDD);
    io(1'b0, 16'h0CFC, 4'h5, 32'h0);
    chk("cfg lanes", rd, 32'h0022_0044);
    io(1'b0, 16'h0CFC, 4'hF, 32'h0);
    chk("cfg lane write", rd, 32'h1122_CC44);
    io(1'b0, 16'h0CFC, 4'h0, 32'h0);
    chk("cfg no lane", rd, 32'h0);
    $display("test data window done");
    foreach (sels[i]) begin
      io(1'b1, 16'h0CF8, 4'hF, sels[i]);
      io(1'b0, 16'h0CFC, 4'hF, 32'h0);
      chk("cfg target", {10'h0, seen},
        {10'h0, sels[i][23:2]});
    end
    $display("test target fields done");
    io(1'b1, 16'h0CF8, 4'h3, 32'h1234_5678);
    chk("sel kept", target_select, 32'h80A5_5A58);
    chk("fwd ctl", {11'h0, fseen[52:32]},
      {11'h0, 1'b1, 4'h3, 16'h0CF8});
    chk("fwd data", fseen[31:0], 32'h1234_5678);
    io(1'b0, 16'h0080, 4'hF, 32'h0);
    chk("other port", rd, 32'hA5A5_0080);
    io(1'b1, 16'h0CF8, 4'hF, 32'h0012_3454);
    io(1'b0, 16'h0CFC, 4'hF, 32'h0);
    chk("window off", rd, 32'hA5A5_0CFC);
    $display("test forwarding done");
    io(1'b1, 16'h0CF8, 4'hF, 32'h8000_0000);
    @(posedge ref_clk);
    nrst <= 1'b0;
    @(posedge ref_clk);
    #1;
    chk("reset sel", target_select, 32'h0);
    chk("reset ready", {31'h0, io_ready}, 32'h1);
    @(posedge ref_clk);
    nrst <= 1'b1;
    io(1'b0, 16'h0CFC, 4'hF, 32'h0);
    chk("reset window", rd, 32'hA5A5_0CFC);
    $display("test reset done");
    end_of_test();
  end
endmodule : pcicap_port_bench
